/* rtl/pms_mgmt_port.v */
`timescale 1ns/10ps
`include "pms_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module pms_mgmt_port #(
    parameter NPORT = 8
) (
    input  wire              ref_clk_i,
    input  wire              rst_i,
    input  wire              mgmt_clk_section_a_i,
    input  wire              mgmt_clk_section_b_i,
    input  wire              mgmt_data_section_a_i,
    output wire              mgmt_data_section_a_o,
    output wire              mgmt_data_section_a_oe_o,
    input  wire              mgmt_data_section_b_i,
    output wire              mgmt_data_section_b_o,
    output wire              mgmt_data_section_b_oe_o,
    output reg               mgmt_irq_n_section_a_o,
    output reg               mgmt_irq_n_section_a_oe_o,
    output reg               mgmt_irq_n_section_b_o,
    output reg               mgmt_irq_n_section_b_oe_o,
    input  wire              serial_mgmt_disable_i,
    input  wire              section_split_i,
    input  wire              hw_power_down_i,
    input  wire [4:0]        phy_base_addr_i,
    input  wire [15:0]       hw_ctrl_straps_i,
    input  wire [NPORT-1:0]  status_change_i,
    output reg  [16*NPORT-1:0] port_ctrl_o,
    output reg  [NPORT-1:0]  port_irq_en_o
);
    localparam [3:0] S_PRE = 4'h1;
    localparam [3:0] S_HDR = 4'h2;
    localparam [3:0] S_TA  = 4'h4;
    localparam [3:0] S_DAT = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // strap and level synchronisers
    reg  [4:0] lvl_s1;
    reg  [4:0] lvl_s2;
    reg  [15:0] strap_s1;
    reg  [15:0] strap_s2;
    reg  [4:0] base_s1;
    reg  [4:0] base_s2;
    reg  [1:0] init_cnt;
    reg        ready;
    reg        serial_mgmt_disable;
    reg        split;
    reg  [NPORT-1:0] sticky;

    wire       pd = lvl_s2[0];

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_s1   <= 5'h00;
            lvl_s2   <= 5'h00;
            strap_s1 <= 16'h0000;
            strap_s2 <= 16'h0000;
            base_s1  <= 5'h00;
            base_s2  <= 5'h00;
        end else begin
            lvl_s1   <= {mgmt_data_section_b_i, mgmt_data_section_a_i,
                         section_split_i, serial_mgmt_disable_i, hw_power_down_i};
            lvl_s2   <= lvl_s1;
            strap_s1 <= hw_ctrl_straps_i;
            strap_s2 <= strap_s1;
            base_s1  <= phy_base_addr_i;
            base_s2  <= base_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-section frame engines
    wire [1:0]  sec_wr;
    wire [5:0]  sec_wport;
    wire [9:0]  sec_wreg;
    wire [31:0] sec_wdat;
    wire [1:0]  sec_clr;
    wire [15:0] sec_maddr;
    wire [1:0]  sec_mwe;
    wire [31:0] sec_mrd;
    wire [1:0]  sec_dout;
    wire [1:0]  sec_doe;

    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_sec
            reg        c1;
            reg        c2;
            reg        c3;
            reg  [3:0] st;
            reg  [5:0] ones;
            reg  [4:0] cnt;
            reg  [11:0] sr;
            reg  [15:0] sh;
            reg        is_rd;
            reg        is_wr;
            reg  [2:0] port;
            reg  [4:0] regn;
            reg        dout;
            reg        doe;
            reg        wr_p;
            reg        clr_p;
            reg        mwe;
            reg  [15:0] wdat;
            wire       mclk = (s == 0) ? mgmt_clk_section_a_i : mgmt_clk_section_b_i;
            wire       d    = lvl_s2[3 + s];
            wire       rise = c2 & ~c3;
            wire       active = ready & ~serial_mgmt_disable & ~pd;
            wire [2:0] p_nx = sr[6:4];
            wire       sec_ok = (s == 0) ? (~split | ~p_nx[2]) : (split & p_nx[2]);
            wire       hit = (sr[8:7] == base_s2[4:3]) & sec_ok & sr[11];
            wire [15:0] rd_val = (regn == `PMS_REG_CTRL) ? port_ctrl_o[port*16 +: 16] :
                                 (regn == `PMS_REG_IRQST) ?
                                 ({15'h0000, sticky[port]} << `PMS_IRQST_BIT) :
                                 sec_mrd[s*16 +: 16];

            always @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    c1 <= 1'b0;
                    c2 <= 1'b0;
                    c3 <= 1'b0;
                end else begin
                    c1 <= mclk;
                    c2 <= c1;
                    c3 <= c2;
                end
            end

            always @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    st    <= S_PRE;
                    ones  <= 6'h00;
                    cnt   <= 5'h00;
                    sr    <= 12'h000;
                    sh    <= 16'h0000;
                    is_rd <= 1'b0;
                    is_wr <= 1'b0;
                    port  <= 3'h0;
                    regn  <= 5'h00;
                    dout  <= 1'b0;
                    doe   <= 1'b0;
                    wr_p  <= 1'b0;
                    clr_p <= 1'b0;
                    mwe   <= 1'b0;
                    wdat  <= 16'h0000;
                end else begin
                    wr_p  <= 1'b0;
                    clr_p <= 1'b0;
                    mwe   <= 1'b0;
                    if (!active) begin
                        st   <= S_PRE;
                        ones <= 6'h00;
                        doe  <= 1'b0;
                    end else if (rise) begin
                        case (st)
                            S_PRE: begin
                                if (d) begin
                                    if (ones != `PMS_PRE_ONES) begin
                                        ones <= ones + 6'h01;
                                    end
                                end else begin
                                    ones <= 6'h00;
                                    if (ones == `PMS_PRE_ONES) begin
                                        st  <= S_HDR;
                                        cnt <= 5'h00;
                                    end
                                end
                            end
                            S_HDR: begin
                                sr  <= {sr[10:0], d};
                                cnt <= cnt + 5'h01;
                                if (cnt == `PMS_HDR_LAST) begin
                                    port  <= p_nx;
                                    regn  <= {sr[3:0], d};
                                    is_rd <= hit & (sr[10:9] == `PMS_OP_RD);
                                    is_wr <= hit & (sr[10:9] == `PMS_OP_WR);
                                    cnt   <= 5'h00;
                                    st    <= S_TA;
                                end
                            end
                            S_TA: begin
                                cnt <= cnt + 5'h01;
                                if (cnt == 5'h00) begin
                                    doe  <= is_rd;
                                    dout <= 1'b0;
                                end else begin
                                    sh   <= rd_val;
                                    dout <= rd_val[15];
                                    cnt  <= 5'h00;
                                    st   <= S_DAT;
                                    // reading the status register clears it; a new event wins
                                    clr_p <= is_rd & (regn == `PMS_REG_IRQST);
                                end
                            end
                            S_DAT: begin
                                cnt <= cnt + 5'h01;
                                if (is_rd) begin
                                    sh   <= {sh[14:0], 1'b0};
                                    dout <= sh[14];
                                end else begin
                                    sh   <= {sh[14:0], d};
                                end
                                if (cnt == `PMS_DATA_LAST) begin
                                    doe  <= 1'b0;
                                    st   <= S_PRE;
                                    wr_p <= is_wr;
                                    mwe  <= is_wr;
                                    wdat <= {sh[14:0], d};
                                end
                            end
                            default: st <= S_PRE;
                        endcase
                    end
                end
            end

            assign sec_wr[s]           = wr_p;
            assign sec_clr[s]          = clr_p;
            assign sec_wport[s*3 +: 3] = port;
            assign sec_wreg[s*5 +: 5]  = regn;
            assign sec_wdat[s*16 +: 16] = wdat;
            assign sec_maddr[s*8 +: 8] = {port, regn};
            assign sec_mwe[s]          = mwe;
            assign sec_dout[s]         = dout;
            assign sec_doe[s]          = doe;
        end
    endgenerate

    assign mgmt_data_section_a_o    = sec_dout[0];
    assign mgmt_data_section_a_oe_o = sec_doe[0];
    assign mgmt_data_section_b_o    = sec_dout[1];
    assign mgmt_data_section_b_oe_o = sec_doe[1];

    pms_regmem #(
        .AW (8),
        .DW (16)
    ) u_mem (
        .clk_i     (ref_clk_i),
        .rst_i     (rst_i),
        .a_we_i    (sec_mwe[0]),
        .a_addr_i  (sec_maddr[7:0]),
        .a_wdata_i (sec_wdat[15:0]),
        .a_rdata_o (sec_mrd[15:0]),
        .b_we_i    (sec_mwe[1]),
        .b_addr_i  (sec_maddr[15:8]),
        .b_wdata_i (sec_wdat[31:16]),
        .b_rdata_o (sec_mrd[31:16])
    );

    ////////////////////////////////////////////////////////////////////////////
    // shared control, strap capture, sticky status, interrupts
    reg [NPORT-1:0] next_sticky;
    reg [NPORT-1:0] irq_on;
    integer i;
    integer j;

    always @* begin
        next_sticky = sticky | status_change_i;
        for (i = 0; i < 2; i = i + 1) begin
            if (sec_clr[i]) begin
                next_sticky[sec_wport[i*3 +: 3]] = status_change_i[sec_wport[i*3 +: 3]];
            end
        end
        irq_on = next_sticky & port_irq_en_o;
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_cnt      <= `PMS_INIT_WAIT;
            ready         <= 1'b0;
            serial_mgmt_disable         <= 1'b0;
            split         <= 1'b0;
            sticky        <= {NPORT{1'b0}};
            port_ctrl_o   <= {NPORT{`PMS_CTRL_RST}};
            port_irq_en_o <= {NPORT{1'b0}};
        end else begin
            sticky <= next_sticky;
            if (!ready) begin
                // straps are taken once the synchronisers hold post-reset values
                if (init_cnt == 2'h0) begin
                    ready       <= 1'b1;
                    serial_mgmt_disable       <= lvl_s2[1];
                    split       <= lvl_s2[2];
                    port_ctrl_o <= {NPORT{strap_s2}};
                end else begin
                    init_cnt <= init_cnt - 2'h1;
                end
            end else begin
                for (j = 0; j < 2; j = j + 1) begin
                    if (sec_wr[j] && sec_wreg[j*5 +: 5] == `PMS_REG_CTRL) begin
                        port_ctrl_o[sec_wport[j*3 +: 3]*16 +: 16] <= sec_wdat[j*16 +: 16];
                    end
                    if (sec_wr[j] && sec_wreg[j*5 +: 5] == `PMS_REG_IRQEN) begin
                        port_irq_en_o[sec_wport[j*3 +: 3]] <=
                            sec_wdat[j*16 + `PMS_IRQEN_BIT];
                    end
                end
            end
        end
    end

    // open-drain: the pin only ever sinks, so the enable carries the level
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mgmt_irq_n_section_a_o    <= 1'b0;
            mgmt_irq_n_section_a_oe_o <= 1'b0;
            mgmt_irq_n_section_b_o    <= 1'b0;
            mgmt_irq_n_section_b_oe_o <= 1'b0;
        end else begin
            mgmt_irq_n_section_a_oe_o <= ~pd & ready &
                (|(irq_on & (split ? 8'h0f : 8'hff)));
            mgmt_irq_n_section_b_oe_o <= ~pd & ready & split & (|(irq_on & 8'hf0));
        end
    end
endmodule

/* rtl/pms_defines.vh */
`ifndef PMS_DEFINES_VH
`define PMS_DEFINES_VH

// management frame layout
`define PMS_PRE_ONES      6'h20
`define PMS_HDR_LAST      5'h0c
`define PMS_DATA_LAST     5'h0f
`define PMS_OP_RD         2'h2
`define PMS_OP_WR         2'h1

// register numbers and field positions
`define PMS_REG_CTRL      5'h00
`define PMS_REG_IRQEN     5'h12
`define PMS_REG_IRQST     5'h13
`define PMS_IRQEN_BIT     1
`define PMS_IRQST_BIT     2

// reset values
`define PMS_CTRL_RST      16'h0000
`define PMS_INIT_WAIT     2'h3

`endif

/* rtl/pms_regmem.v */
`timescale 1ns/10ps
// two-port register store, one port per management section, registered read data
module pms_regmem #(
    parameter AW = 8,
    parameter DW = 16
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          a_we_i,
    input  wire [AW-1:0] a_addr_i,
    input  wire [DW-1:0] a_wdata_i,
    output reg  [DW-1:0] a_rdata_o,
    input  wire          b_we_i,
    input  wire [AW-1:0] b_addr_i,
    input  wire [DW-1:0] b_wdata_i,
    output reg  [DW-1:0] b_rdata_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // both sections never address the same port, so no write collision is handled
    always @(posedge clk_i) begin
        if (a_we_i) begin
            mem[a_addr_i] <= a_wdata_i;
        end
        if (b_we_i) begin
            mem[b_addr_i] <= b_wdata_i;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_rdata_o <= {DW{1'b0}};
            b_rdata_o <= {DW{1'b0}};
        end else begin
            a_rdata_o <= mem[a_addr_i];
            b_rdata_o <= mem[b_addr_i];
        end
    end
endmodule

/* bench/pms_checker.sv */
`timescale 1ns/10ps
module pms_checker #(
    parameter NPORT = 8
) (
    input logic                 ref_clk_i,
    input logic                 rst_i,
    input logic                 mgmt_data_section_a_o,
    input logic                 mgmt_data_section_a_oe_o,
    input logic                 mgmt_data_section_b_oe_o,
    input logic                 mgmt_irq_n_section_a_oe_o,
    input logic                 mgmt_irq_n_section_b_oe_o,
    input logic                 serial_mgmt_disable_i,
    input logic                 section_split_i,
    input logic                 hw_power_down_i,
    input logic [15:0]          hw_ctrl_straps_i,
    input logic [NPORT-1:0]     status_change_i,
    input logic [16*NPORT-1:0]  port_ctrl_o,
    input logic [NPORT-1:0]     port_irq_en_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // five samples leave room for the two-stage synchroniser and the output flop
    sequence pd_hold_s;
        hw_power_down_i [*5];
    endsequence
    sequence ta_drive_s;
        (mgmt_data_section_a_oe_o && !mgmt_data_section_a_o) [*6];
    endsequence
    AST_RST_FLOAT: assert property (
        $fell(rst_i) |-> !mgmt_data_section_a_oe_o && !mgmt_data_section_b_oe_o
            && !mgmt_irq_n_section_a_oe_o && !mgmt_irq_n_section_b_oe_o)
        else $error("outputs driven right after reset");
    AST_PD_FLOAT: assert property (
        pd_hold_s |-> !mgmt_data_section_a_oe_o && !mgmt_data_section_b_oe_o
            && !mgmt_irq_n_section_a_oe_o && !mgmt_irq_n_section_b_oe_o)
        else $error("outputs driven in power-down");
    AST_B_SINGLE: assert property (
        !section_split_i |-> !mgmt_data_section_b_oe_o && !mgmt_irq_n_section_b_oe_o)
        else $error("section b active in single mode");
    AST_DIS_QUIET: assert property (
        serial_mgmt_disable_i |-> !mgmt_data_section_a_oe_o && !mgmt_data_section_b_oe_o)
        else $error("data driven with serial port disabled");
    AST_DIS_HOLD: assert property (
        serial_mgmt_disable_i && port_ctrl_o == {NPORT{hw_ctrl_straps_i}}
            |=> $stable(port_ctrl_o))
        else $error("control changed with serial port disabled");
    AST_STRAP_LOAD: assert property (
        $fell(rst_i) |-> ##[3:5] port_ctrl_o == {NPORT{hw_ctrl_straps_i}})
        else $error("straps not loaded after reset");
    AST_IRQ_A: assert property (
        status_change_i[0] && port_irq_en_o[0] && !hw_power_down_i
            |=> mgmt_irq_n_section_a_oe_o)
        else $error("section a interrupt missing");
    AST_IRQ_B: assert property (
        section_split_i && status_change_i[4] && port_irq_en_o[4] && !hw_power_down_i
            |=> mgmt_irq_n_section_b_oe_o)
        else $error("section b interrupt missing");
    AST_IRQ_QUIET: assert property (
        (port_irq_en_o == '0) [*2] |-> !mgmt_irq_n_section_a_oe_o && !mgmt_irq_n_section_b_oe_o)
        else $error("interrupt without enable");
    AST_TA_ZERO: assert property (
        $rose(mgmt_data_section_a_oe_o) |-> ta_drive_s)
        else $error("turnaround not driven low");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pms_mgmt_port pms_checker #(.NPORT(NPORT)) i_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .mgmt_data_section_a_o(mgmt_data_section_a_o),
    .mgmt_data_section_a_oe_o(mgmt_data_section_a_oe_o),
    .mgmt_data_section_b_oe_o(mgmt_data_section_b_oe_o),
    .mgmt_irq_n_section_a_oe_o(mgmt_irq_n_section_a_oe_o),
    .mgmt_irq_n_section_b_oe_o(mgmt_irq_n_section_b_oe_o),
    .serial_mgmt_disable_i(serial_mgmt_disable_i), .section_split_i(section_split_i),
    .hw_power_down_i(hw_power_down_i), .hw_ctrl_straps_i(hw_ctrl_straps_i),
    .status_change_i(status_change_i), .port_ctrl_o(port_ctrl_o),
    .port_irq_en_o(port_irq_en_o));

/* bench/pms_mgmt_master.sv */
`timescale 1ns/10ps
module pms_mgmt_master (
    input  wire logic dev_o_i,
    input  wire logic dev_oe_i,
    output logic      mdc_o,
    output wire logic line_o
);
    logic m_oe = 1'b0;
    logic m_bit = 1'b1;
    initial mdc_o = 1'b0;
    // a released line rises through the pull-up
    assign line_o = dev_oe_i ? dev_o_i : (m_oe ? m_bit : 1'b1);
    ////////////////////////////////////////////////////////////////////////
    // 400 ns bit time, clock held low between frames
    task automatic bit_cyc(input logic b, input logic drv, output logic smp);
        m_oe = drv;
        m_bit = b;
        #200 mdc_o = 1'b1;
        smp = line_o;
        #200 mdc_o = 1'b0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        s;
        hdr = {2'b01, op, phy, rg};
        for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
        bit_cyc(1'b1, op == 2'h1, s);
        bit_cyc(1'b0, op == 2'h1, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(wd[i], op == 2'h1, s);
            rd[i] = s;
        end
        m_oe = 1'b0;
    endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/10ps
module tb;
    logic         ref_clk, rst, split, dis, pd;
    logic [15:0]  straps;
    logic [7:0]   status, irq_en;
    logic         clk_a, clk_b, da_o, da_oe, db_o, db_oe, ia_o, ia_oe, ib_o, ib_oe;
    wire          line_a, line_b;
    logic [127:0] ctrl;
    int           n_mismatch = 0;
    int           checked = 0;

    pms_mgmt_port i_dut (
        .ref_clk_i(ref_clk), .rst_i(rst), .mgmt_clk_section_a_i(clk_a),
        .mgmt_clk_section_b_i(clk_b), .mgmt_data_section_a_i(line_a),
        .mgmt_data_section_a_o(da_o), .mgmt_data_section_a_oe_o(da_oe),
        .mgmt_data_section_b_i(line_b), .mgmt_data_section_b_o(db_o),
        .mgmt_data_section_b_oe_o(db_oe), .mgmt_irq_n_section_a_o(ia_o),
        .mgmt_irq_n_section_a_oe_o(ia_oe), .mgmt_irq_n_section_b_o(ib_o),
        .mgmt_irq_n_section_b_oe_o(ib_oe), .serial_mgmt_disable_i(dis),
        .section_split_i(split), .hw_power_down_i(pd), .phy_base_addr_i(5'h08),
        .hw_ctrl_straps_i(straps), .status_change_i(status), .port_ctrl_o(ctrl),
        .port_irq_en_o(irq_en));
    pms_mgmt_master i_ma (.dev_o_i(da_o), .dev_oe_i(da_oe), .mdc_o(clk_a), .line_o(line_a));
    pms_mgmt_master i_mb (.dev_o_i(db_o), .dev_oe_i(db_oe), .mdc_o(clk_b), .line_o(line_b));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // straps change only under reset, as the design latches them on the fourth clock after release
    task automatic do_reset(input logic sp, input logic ds, input logic [15:0] st);
        @(negedge ref_clk);
        rst = 1'b1;
        split = sp;
        dis = ds;
        straps = st;
        repeat (10) @(negedge ref_clk);
        chk("oe in reset", 16'h0, {12'h0, da_oe, db_oe, ia_oe, ib_oe});
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("ctrl port0", st, ctrl[15:0]);
        chk("ctrl port7", st, ctrl[127:112]);
    endtask
    task automatic xfer(input logic sec, input logic [1:0] op, input logic [2:0] p,
                        input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
        #13;
        if (sec)
            i_mb.frame(op, {2'b01, p}, rg, wd, rd);
        else
            i_ma.frame(op, {2'b01, p}, rg, wd, rd);
        repeat (7) @(negedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_single();
        logic [15:0] d;
        xfer(1'b0, 2'h1, 3'd5, 5'h00, 16'ha5c3, d);
        chk("port5 ctrl via a", 16'ha5c3, ctrl[95:80]);
        xfer(1'b1, 2'h1, 3'd5, 5'h00, 16'h0001, d);
        chk("port5 ctrl via b", 16'ha5c3, ctrl[95:80]);
        xfer(1'b0, 2'h2, 3'd5, 5'h00, 16'h0000, d);
        chk("port5 read", 16'ha5c3, d);
        xfer(1'b0, 2'h1, 3'd2, 5'h1f, 16'h5a3c, d);
        xfer(1'b0, 2'h2, 3'd2, 5'h1f, 16'h0000, d);
        chk("reg31 read", 16'h5a3c, d);
        xfer(1'b1, 2'h2, 3'd2, 5'h1f, 16'h0000, d);
        chk("reg31 read via b", 16'hffff, d);
        chk("port0 ctrl kept", 16'h1140, ctrl[15:0]);
    endtask
    task automatic t_split();
        logic [15:0] d;
        xfer(1'b1, 2'h1, 3'd6, 5'h00, 16'h0c0f, d);
        chk("port6 via b", 16'h0c0f, ctrl[111:96]);
        xfer(1'b1, 2'h1, 3'd1, 5'h00, 16'h0c0f, d);
        chk("port1 via b", 16'h3100, ctrl[31:16]);
        xfer(1'b0, 2'h2, 3'd6, 5'h00, 16'h0000, d);
        chk("port6 read via a", 16'hffff, d);
        xfer(1'b1, 2'h2, 3'd6, 5'h00, 16'h0000, d);
        chk("port6 read via b", 16'h0c0f, d);
    endtask
    task automatic t_irq();
        logic [15:0] d;
        xfer(1'b0, 2'h1, 3'd0, 5'h12, 16'h0002, d);
        xfer(1'b1, 2'h1, 3'd4, 5'h12, 16'h0002, d);
        chk("irq enables", 16'h0011, {8'h0, irq_en});
        status = 8'h22;
        @(negedge ref_clk);
        status = 8'h00;
        repeat (2) @(negedge ref_clk);
        chk("irq masked", 16'h0, {14'h0, ia_oe, ib_oe});
        status = 8'h11;
        @(negedge ref_clk);
        status = 8'h00;
        repeat (2) @(negedge ref_clk);
        chk("irq both", 16'h3, {14'h0, ia_oe, ib_oe});
        chk("irq pin level", 16'h0, {14'h0, ia_o, ib_o});
        xfer(1'b0, 2'h2, 3'd0, 5'h13, 16'h0000, d);
        chk("status bit", 16'h0004, d & 16'h0004);
        chk("irq after clear", 16'h1, {14'h0, ia_oe, ib_oe});
        pd = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("irq in power-down", 16'h0, {14'h0, ia_oe, ib_oe});
        xfer(1'b1, 2'h2, 3'd6, 5'h00, 16'h0000, d);
        chk("read in power-down", 16'hffff, d);
        pd = 1'b0;
    endtask
    task automatic t_disable();
        logic [15:0] d;
        xfer(1'b0, 2'h1, 3'd0, 5'h00, 16'h0f0f, d);
        chk("ctrl with port off", 16'h2100, ctrl[15:0]);
        xfer(1'b0, 2'h2, 3'd0, 5'h00, 16'h0000, d);
        chk("read with port off", 16'hffff, d);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        split = 1'b0;
        dis = 1'b0;
        pd = 1'b0;
        straps = 16'h1140;
        status = 8'h00;
        do_reset(1'b0, 1'b0, 16'h1140);
        t_single();
        do_reset(1'b1, 1'b0, 16'h3100);
        t_split();
        t_irq();
        do_reset(1'b0, 1'b1, 16'h2100);
        t_disable();
        finish_test();
    end
    // sixteen frames of 26 us each are expected
    initial begin
        #2000000;
        n_mismatch++;
        finish_test();
    end
endmodule
